// *** pkg/tcit_pkg.sv ***
// Purpose: Shared constants and arithmetic for the two-channel interval timer.
// Assumes: Byte-wide processor I/O ports, one 40 MHz system clock.
// Notes:   Channel 0 is the general channel, channel 1 the tone channel.
//
// Behaviour
// (RL1) Two channels: general interrupt, speaker tone
// (RL2) General channel refuses one-shot and hardware strobe
// (RL3) Count clock is processor clock over four
// (RL4) Processor clock is oscillator over three, 33% high
// (RL5) Software writes control word before count bytes
// (RL6) Channels count down once per count clock; square mode steps down by two per count clock
// (RL7) Count ports 40h and 42h, control 43h
// (RL8) Single-byte count load zeroes the other byte
// (RL9) Latch captures count, counting carries on undisturbed
// (RL10) Select bits: 00 general, 10 tone, x1 suspend
// (RL11) Access bits: latch, low, high, low-then-high
// (RL12) Mode bits choose six counting modes
// (RL13) Bit 0 picks BCD or binary counting
// (RL14) Misc port 61h bit 0 gates tone channel
// (RL15) Sense port 62h bit 5 shows tone output
// (RL16) Firmware sets general channel to square wave
// (RL17) Rate pulses low at one; square halves
// (RL18) General channel output drives interrupt level 0
`default_nettype none

package tcit_pkg;

    // ------------------------------------------------------------
    // Port addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CNT_GEN  = 8'h40;
    localparam logic [7:0] ADDR_CNT_TONE = 8'h42;
    localparam logic [7:0] ADDR_CTRL     = 8'h43;
    localparam logic [7:0] ADDR_MISC     = 8'h61;
    localparam logic [7:0] ADDR_SENSE    = 8'h62;

    // ------------------------------------------------------------
    // Control word layout
    // ------------------------------------------------------------
    localparam int CW_SEL_HI   = 7;
    localparam int CW_SEL_LO   = 6;
    localparam int CW_RW_HI    = 5;
    localparam int CW_RW_LO    = 4;
    localparam int CW_MODE_HI  = 3;
    localparam int CW_MODE_LO  = 1;
    localparam int CW_BCD      = 0;

    localparam logic [1:0] SEL_GEN  = 2'h0;
    localparam logic [1:0] SEL_TONE = 2'h2;

    localparam logic [1:0] RW_LATCH = 2'h0;
    localparam logic [1:0] RW_LSB   = 2'h1;
    localparam logic [1:0] RW_MSB   = 2'h2;
    localparam logic [1:0] RW_BOTH  = 2'h3;

    localparam logic [2:0] MODE_TERM    = 3'h0;
    localparam logic [2:0] MODE_ONESHOT = 3'h1;
    localparam logic [2:0] MODE_RATE    = 3'h2;
    localparam logic [2:0] MODE_SQUARE  = 3'h3;
    localparam logic [2:0] MODE_SWSTB   = 3'h4;
    localparam logic [2:0] MODE_HWSTB   = 3'h5;

    // ------------------------------------------------------------
    // Misc and sense ports, reset values, dividers
    // ------------------------------------------------------------
    localparam int         MISC_GATE_BIT   = 0;
    localparam logic [7:0] SENSE_OUT_MASK  = 8'h20;
    localparam logic [7:0] MISC_RESET      = 8'h00;
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam logic [2:0] MODE_RESET      = 3'h0;
    localparam logic [1:0] RW_RESET        = 2'h3;
    localparam logic       OUT_RESET       = 1'b0;
    localparam logic [1:0] OSC_DIV_LAST    = 2'h2;
    localparam logic [1:0] CNT_DIV_LAST    = 2'h3;

    // One step down in binary or four-digit BCD; zero wraps to the top
    function automatic logic [15:0] tcit_dec(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        logic        borrow;
        r      = v;
        borrow = 1'b1;
        if (!bcd) begin
            r = v - 16'h0001;
        end else begin
            for (int d = 0; d < 4; d++) begin
                if (borrow) begin
                    if (r[4*d +: 4] == 4'h0) begin
                        r[4*d +: 4] = 4'h9;
                    end else begin
                        r[4*d +: 4] = r[4*d +: 4] - 4'h1;
                        borrow      = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction : tcit_dec

endpackage : tcit_pkg

`default_nettype wire

// *** design/tcit_clkdiv.sv ***
// Purpose: Derive the processor clock and the channel count strobe.
// Assumes: osc_tick pulses once per oscillator period, synchronous to clk.
// Notes:   Both outputs are registered; cnt_tick is a one-cycle strobe.
`default_nettype none

module tcit_clkdiv import tcit_pkg::*; (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Oscillator strobe
    input  wire logic osc_tick,
    // Derived timing
    output logic      proc_clk,
    output logic      cnt_tick
);

    logic [1:0] osc_ph;
    logic [1:0] proc_ph;
    logic       proc_rise;

    // Processor period ends on the third oscillator strobe
    assign proc_rise = osc_tick && (osc_ph == OSC_DIV_LAST);

    // --------------------------------------------------------------
    // Divide by three, high for one third
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_ph   <= 2'h0;
            proc_clk <= 1'b0;
        end else if (osc_tick) begin
            osc_ph   <= proc_rise ? 2'h0 : osc_ph + 2'h1;
            proc_clk <= proc_rise; // RL4
        end
    end

    // --------------------------------------------------------------
    // Divide processor clock by four
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            proc_ph  <= 2'h0;
            cnt_tick <= 1'b0;
        end else begin
            cnt_tick <= proc_rise && (proc_ph == CNT_DIV_LAST); // RL3
            if (proc_rise) begin
                proc_ph <= proc_ph + 2'h1;
            end
        end
    end

    chk_third_high: assert property (@(posedge clk) disable iff (!rst_n) // RL4
        osc_tick |=> proc_clk == ($past(osc_ph) == OSC_DIV_LAST))
        else $error("processor clock high phase wrong");

    chk_tick_quarter: assert property (@(posedge clk) disable iff (!rst_n) // RL3
        cnt_tick |-> $past(proc_rise) && proc_ph == 2'h0)
        else $error("count strobe not every fourth processor period");

endmodule : tcit_clkdiv

`default_nettype wire

// *** design/tcit_timer.sv ***
// Purpose: Two-channel interval timer behind byte-wide processor I/O ports.
// Assumes: I/O strobes last one clock; reads and writes never coincide.
// Notes:   Channel 0 feeds interrupt level 0, channel 1 feeds the speaker.
`default_nettype none

module tcit_timer import tcit_pkg::*; (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Oscillator strobe
    input  wire logic       osc_tick,
    // Processor I/O cycle
    input  wire logic [7:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    // Channel outputs
    output logic            irq0,
    output logic            tone_out,
    // System side signals
    output logic            proc_clk,
    output logic            suspend_req
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic        cnt_tick;
    logic        cw_wr;
    logic        cw_susp;
    logic        cw_gen_ok;
    logic [1:0]  cw_sel;
    logic [1:0]  cw_rw;
    logic [2:0]  cw_field;
    logic [2:0]  cw_mode;
    logic [7:0]  misc_ctrl;
    logic [7:0]  ctrl_last;
    logic [7:0]  sense_val;
    logic [7:0]  next_rdata;

    logic        cw_hit    [2];
    logic        cfg_hit   [2];
    logic        latch_hit [2];
    logic        cnt_wr    [2];
    logic        cnt_rd    [2];
    logic        gate      [2];
    logic [7:0]  rd_byte   [2];

    logic [15:0] cnt     [2];
    logic [15:0] init    [2];
    logic [15:0] lat     [2];
    logic [2:0]  mode    [2];
    logic [1:0]  rw      [2];
    logic        bcd     [2];
    logic        out     [2];
    logic        pend    [2];
    logic        armed   [2];
    logic        run     [2];
    logic        trig    [2];
    logic        wflip   [2];
    logic        rflip   [2];
    logic        latched [2];
    logic        gate_q  [2];

    // ------------------------------------------------------------
    // Clock derivation
    // ------------------------------------------------------------
    tcit_clkdiv u_div (
        .clk      (clk),
        .rst_n    (rst_n),
        .osc_tick (osc_tick),
        .proc_clk (proc_clk),
        .cnt_tick (cnt_tick)
    );

    // ------------------------------------------------------------
    // Control word decode
    // ------------------------------------------------------------
    // Mode field x10/x11 folded onto the two canonical codes
    assign cw_wr     = io_wr && (io_addr == ADDR_CTRL);
    assign cw_sel    = io_wdata[CW_SEL_HI:CW_SEL_LO];
    assign cw_rw     = io_wdata[CW_RW_HI:CW_RW_LO];
    assign cw_field  = io_wdata[CW_MODE_HI:CW_MODE_LO];
    assign cw_mode   = cw_field[1] ? {1'b0, cw_field[1:0]} : cw_field; // RL12
    assign cw_susp   = cw_wr && io_wdata[CW_SEL_LO]; // RL10
    assign cw_gen_ok = (cw_mode != MODE_ONESHOT) && (cw_mode != MODE_HWSTB); // RL2

    // Unsupported general modes are dropped whole, so the old setup keeps running
    assign cw_hit[0] = cw_wr && (cw_sel == SEL_GEN) && (cw_rw == RW_LATCH || cw_gen_ok); // RL10
    assign cw_hit[1] = cw_wr && (cw_sel == SEL_TONE); // RL10

    // Count port strobes and gates
    assign cnt_wr[0] = io_wr && (io_addr == ADDR_CNT_GEN); // RL7
    assign cnt_wr[1] = io_wr && (io_addr == ADDR_CNT_TONE); // RL7
    assign cnt_rd[0] = io_rd && (io_addr == ADDR_CNT_GEN);
    assign cnt_rd[1] = io_rd && (io_addr == ADDR_CNT_TONE);
    assign gate[0]   = 1'b1;
    assign gate[1]   = misc_ctrl[MISC_GATE_BIT]; // RL14

    // ------------------------------------------------------------
    // Counter channels
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_ch
        logic [15:0] dec1;
        logic [15:0] dec2;
        logic [15:0] src;
        logic        trig_mode;
        logic        strobe_mode;
        logic        free_mode;
        logic        gate_ok;
        logic        load_req;
        logic        read_done;

        // Step values and mode classes
        assign dec1        = tcit_dec(cnt[i], bcd[i]); // RL13
        assign dec2        = tcit_dec(dec1, bcd[i]);
        assign trig_mode   = (mode[i] == MODE_ONESHOT) || (mode[i] == MODE_HWSTB);
        assign strobe_mode = (mode[i] == MODE_SWSTB) || (mode[i] == MODE_HWSTB);
        assign free_mode   = (mode[i] == MODE_RATE) || (mode[i] == MODE_SQUARE);
        assign gate_ok     = gate[i] || trig_mode;
        assign cfg_hit[i]  = cw_hit[i] && (cw_rw != RW_LATCH);
        assign latch_hit[i] = cw_hit[i] && (cw_rw == RW_LATCH); // RL11
        assign load_req    = cnt_wr[i] && (rw[i] != RW_BOTH || wflip[i]);

        // Read path: latched snapshot wins over the live count
        assign src        = latched[i] ? lat[i] : cnt[i]; // RL9
        assign rd_byte[i] = (rw[i] == RW_MSB || (rw[i] == RW_BOTH && rflip[i])) ?
                            src[15:8] : src[7:0]; // RL11
        assign read_done  = (rw[i] != RW_BOTH) || rflip[i];

        // Setup, count load bytes, latch and read sequencing
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                mode[i]    <= MODE_RESET;
                rw[i]      <= RW_RESET;
                bcd[i]     <= 1'b0;
                init[i]    <= 16'h0000;
                lat[i]     <= 16'h0000;
                armed[i]   <= 1'b0;
                wflip[i]   <= 1'b0;
                rflip[i]   <= 1'b0;
                latched[i] <= 1'b0;
            end else if (cfg_hit[i]) begin
                mode[i]    <= cw_mode; // RL12
                rw[i]      <= cw_rw; // RL11
                bcd[i]     <= io_wdata[CW_BCD]; // RL13
                armed[i]   <= 1'b0; // RL5
                wflip[i]   <= 1'b0;
                rflip[i]   <= 1'b0;
                latched[i] <= 1'b0;
            end else if (latch_hit[i] && !latched[i]) begin
                lat[i]     <= cnt[i]; // RL9
                latched[i] <= 1'b1;
            end else if (cnt_wr[i]) begin
                unique case (rw[i])
                    RW_LSB: begin
                        init[i]  <= {8'h00, io_wdata}; // RL8
                        armed[i] <= 1'b1;
                    end
                    RW_MSB: begin
                        init[i]  <= {io_wdata, 8'h00}; // RL8
                        armed[i] <= 1'b1;
                    end
                    default: begin
                        if (wflip[i]) begin
                            init[i][15:8] <= io_wdata;
                            armed[i]      <= 1'b1;
                        end else begin
                            init[i][7:0]  <= io_wdata;
                        end
                        wflip[i] <= !wflip[i];
                    end
                endcase
            end else if (cnt_rd[i]) begin
                rflip[i] <= (rw[i] == RW_BOTH) ? !rflip[i] : 1'b0;
                if (read_done) begin
                    latched[i] <= 1'b0;
                end
            end
        end

        // Gate history for triggered modes
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                gate_q[i] <= 1'b0;
            end else begin
                gate_q[i] <= gate[i];
            end
        end

        // Counting engine; latch and reads never touch it
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                cnt[i]  <= 16'h0000;
                out[i]  <= OUT_RESET;
                pend[i] <= 1'b0;
                run[i]  <= 1'b0;
                trig[i] <= 1'b0;
            end else if (cfg_hit[i]) begin
                out[i]  <= (cw_mode != MODE_TERM);
                pend[i] <= 1'b0;
                run[i]  <= 1'b0;
                trig[i] <= 1'b0;
            end else if (load_req) begin
                // Triggered modes wait for a gate edge instead
                pend[i] <= !trig_mode;
                if (mode[i] == MODE_TERM) begin
                    out[i] <= 1'b0;
                end
            end else begin
                if (trig_mode && gate[i] && !gate_q[i]) begin
                    trig[i] <= 1'b1;
                end
                if (cnt_tick) begin
                    if (trig_mode && trig[i] && armed[i]) begin
                        cnt[i]  <= init[i];
                        run[i]  <= 1'b1;
                        trig[i] <= gate[i] && !gate_q[i]; // Fresh edge survives
                        out[i]  <= (mode[i] != MODE_ONESHOT);
                    end else if (pend[i]) begin
                        if (gate_ok) begin
                            cnt[i]  <= init[i];
                            pend[i] <= 1'b0;
                            run[i]  <= 1'b1;
                        end
                    end else if (run[i] && gate_ok) begin
                        unique case (mode[i])
                            MODE_TERM: begin
                                cnt[i] <= dec1; // RL6
                                if (cnt[i] == 16'h0001) begin
                                    out[i] <= 1'b1;
                                end
                            end
                            MODE_RATE: begin
                                out[i] <= (cnt[i] != 16'h0002); // RL17
                                cnt[i] <= (cnt[i] == 16'h0001) ? init[i] : dec1; // RL17
                            end
                            MODE_SQUARE: begin
                                // Odd counts pass through one before reload
                                if (cnt[i] == 16'h0002 || cnt[i] == 16'h0001) begin
                                    cnt[i] <= init[i]; // RL17
                                    out[i] <= !out[i]; // RL17
                                end else begin
                                    cnt[i] <= dec2;
                                end
                            end
                            MODE_ONESHOT, MODE_SWSTB, MODE_HWSTB: begin
                                cnt[i] <= dec1; // RL6
                                if (cnt[i] == 16'h0001) begin
                                    run[i] <= 1'b0;
                                    out[i] <= (mode[i] == MODE_ONESHOT);
                                end
                            end
                            default: begin
                                cnt[i] <= cnt[i];
                            end
                        endcase
                    end else if (!gate_ok && free_mode) begin
                        out[i] <= 1'b1; // RL14
                    end else if (!run[i] && strobe_mode) begin
                        out[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read mux and host registers
    // ------------------------------------------------------------
    // Unmapped addresses read as zero
    assign sense_val  = {8{out[1]}} & SENSE_OUT_MASK; // RL15
    assign next_rdata = (io_addr == ADDR_CNT_GEN)  ? rd_byte[0] :
                        (io_addr == ADDR_CNT_TONE) ? rd_byte[1] :
                        (io_addr == ADDR_CTRL)     ? ctrl_last  :
                        (io_addr == ADDR_MISC)     ? misc_ctrl  :
                        (io_addr == ADDR_SENSE)    ? sense_val  : 8'h00;

    // Misc, control readback, read data and side outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            misc_ctrl   <= MISC_RESET;
            ctrl_last   <= CTRL_RESET;
            io_rdata    <= 8'h00;
            irq0        <= OUT_RESET;
            tone_out    <= OUT_RESET;
            suspend_req <= 1'b0;
        end else begin
            if (io_wr && io_addr == ADDR_MISC) begin
                misc_ctrl <= io_wdata; // RL14
            end
            if (cw_wr) begin
                ctrl_last <= io_wdata;
            end
            if (io_rd) begin
                io_rdata <= next_rdata;
            end
            irq0        <= out[0]; // RL18
            tone_out    <= out[1]; // RL1
            suspend_req <= cw_susp; // RL10
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_gen_run;
        cnt_tick && run[0] && !pend[0] && !cfg_hit[0] && !cnt_wr[0];
    endsequence

    sequence s_rate_two;
        s_gen_run ##0 (mode[0] == MODE_RATE && cnt[0] == 16'h0002);
    endsequence

    chk_gen_modes: assert property ( // RL2
        mode[0] != MODE_ONESHOT && mode[0] != MODE_HWSTB)
        else $error("general channel holds an unsupported mode");

    chk_term_step: assert property ( // RL6
        s_gen_run ##0 (mode[0] == MODE_TERM) |=> cnt[0] == $past(g_ch[0].dec1))
        else $error("count did not step down once");

    chk_latch_free: assert property ( // RL9
        s_gen_run ##0 (latched[0] && mode[0] == MODE_TERM)
        |=> cnt[0] == $past(g_ch[0].dec1) && lat[0] == $past(lat[0]))
        else $error("latched snapshot disturbed counting");

    chk_lsb_zero: assert property ( // RL8
        cnt_wr[0] && rw[0] == RW_LSB && !cfg_hit[0] |=> init[0][15:8] == 8'h00)
        else $error("high byte not forced to zero");

    chk_gate_stop: assert property ( // RL14
        cnt_tick && !gate[1] && !g_ch[1].trig_mode && !cfg_hit[1] && !cnt_wr[1]
        |=> $stable(cnt[1]))
        else $error("tone channel counted with gate low");

    chk_rate_pulse: assert property ( // RL17
        s_rate_two |=> !out[0] && cnt[0] == 16'h0001)
        else $error("rate output not low at count one");

    chk_square_tog: assert property ( // RL17
        s_gen_run ##0 (mode[0] == MODE_SQUARE && cnt[0] == 16'h0002)
        |=> out[0] != $past(out[0]) && cnt[0] == $past(init[0]))
        else $error("square wave did not toggle and reload");

    chk_irq_track: assert property ( // RL18
        $rose(out[0]) |=> $rose(irq0))
        else $error("interrupt request missed a rising output");

    chk_sense_bit: assert property ( // RL15
        io_rd && io_addr == ADDR_SENSE
        |=> io_rdata == ($past(out[1]) ? SENSE_OUT_MASK : 8'h00))
        else $error("sense port does not show tone output");

    chk_suspend: assert property ( // RL10
        cw_wr && io_wdata[CW_SEL_LO] |=> suspend_req && $stable(mode[1]) && $stable(mode[0]))
        else $error("suspend select reached a channel");

endmodule : tcit_timer

`default_nettype wire

// *** bench/two_channel_interval_timer_bench.sv ***
// Purpose: Self-checking bench for the two-channel interval timer.
// Assumes: osc_tick held high, so one count strobe every 12 clocks.
// Notes:   Periods are measured between rising edges, skipping the first.
`default_nettype none
module two_channel_interval_timer_bench import tcit_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, osc_tick, io_wr, io_rd, irq0, tone_out, proc_clk, suspend_req;
    logic [7:0]  io_addr, io_wdata, io_rdata, d, r;
    logic [15:0] v1, v2;
    int          err_count, check_count, per, lo, c1, cyc = 0, seed = 97;

    tcit_timer u_tcit_timer (.clk(clk), .rst_n(rst_n), .osc_tick(osc_tick),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .irq0(irq0), .tone_out(tone_out), .proc_clk(proc_clk),
        .suspend_req(suspend_req));

    // Clock and cycle count
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk
    // One idle cycle between accesses keeps each strobe a clean pulse
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= v;
        io_wr    <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        #1 v = io_rdata;
    endtask : rd
    task automatic prog(input logic [7:0] a, input logic [7:0] cw, input logic [15:0] c);
        wr(ADDR_CTRL, cw);
        if (cw[5:4] != RW_MSB) wr(a, c[7:0]);
        if (cw[5:4] != RW_LSB) wr(a, c[15:8]);
    endtask : prog
    function automatic int exp_cnt(input logic [15:0] c, input logic bcd);
        return bcd ? c[15:12] * 1000 + c[11:8] * 100 + c[7:4] * 10 + c[3:0] : c;
    endfunction : exp_cnt
    task automatic meas(input logic w, output int p, output int l);
        int   e;
        logic s, q;
        e = 0; p = 0; l = 0; q = 1'b1;
        for (int n = 0; n < 12000 && e < 3; n++) begin
            @(posedge clk);
            #1 s = w ? tone_out : irq0;
            if (e == 2) p++;
            if (e == 2 && s !== 1'b1) l++;
            if (s === 1'b1 && q === 1'b0) e++;
            q = s;
        end
    endtask : meas
    // Square halves the count; rate pulses low one count clock
    task automatic run(input logic w, input logic [7:0] cw, input logic [15:0] c);
        int n;
        n = exp_cnt(c, cw[0]);
        prog(w ? ADDR_CNT_TONE : ADDR_CNT_GEN, cw, c);
        meas(w, per, lo);
        chk("period", 16'(12 * n), 16'(per));
        chk("low", (cw[2:1] == 2'b11) ? 16'(6 * n) : 16'd12, 16'(lo));
    endtask : run
    // Tone count 4, one gate rise, then count low cycles in a fixed window
    task automatic strobe(input logic [7:0] cw, input int e);
        prog(ADDR_CNT_TONE, cw, 16'h0004);
        wr(ADDR_MISC, 8'h00);
        wr(ADDR_MISC, 8'h01);
        lo = 0;
        repeat (100) begin
            @(posedge clk);
            #1 lo += (tone_out !== 1'b1);
        end
        chk("strobe_low", 16'(e), 16'(lo));
    endtask : strobe
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    // --------------------------------------------------------
    // Tests
    // --------------------------------------------------------
    initial begin
        rst_n = 1'b0; osc_tick = 1'b1; io_wr = 1'b0; io_rd = 1'b0;
        io_addr = 8'h00; io_wdata = 8'h00; err_count = 0; check_count = 0;
        repeat (12) @(posedge clk);
        chk("reset", 16'h0000,
            {11'h000, io_rdata != 8'h00, irq0, tone_out, proc_clk, suspend_req});
        rst_n <= 1'b1;
        r = 8'($random(seed));
        wr(ADDR_MISC, r);
        rd(ADDR_MISC, d); chk("misc", r, d);
        rd(8'h55, d); chk("unmapped", 16'h0000, d);
        wr(ADDR_SENSE, 8'hFF);
        rd(ADDR_SENSE, d); chk("sense_rsvd", 16'h0000, d & 8'hDF);
        wr(ADDR_CTRL, 8'h40); #1 chk("suspend", 16'h0001, suspend_req);
        @(posedge clk); #1 chk("suspend_end", 16'h0000, suspend_req);
        rd(ADDR_CTRL, d); chk("ctrl_rd", 16'h0040, d);
        per = 0;
        repeat (30) begin
            @(posedge clk);
            #1 per += (proc_clk === 1'b1);
        end
        chk("proc_high", 16'd10, 16'(per));
        wr(ADDR_MISC, 8'h00);
        prog(ADDR_CNT_TONE, 8'h96, 16'h0004);
        repeat (100) @(posedge clk);
        #1 chk("gate_off", 16'h0001, tone_out);
        rd(ADDR_SENSE, d); chk("sense", 16'h0020, d);
        wr(ADDR_MISC, 8'h01);
        run(1'b1, 8'h96, 16'h0004);
        prog(ADDR_CNT_TONE, 8'h90, 16'h0003);
        #1 chk("term_low", 16'h0000, tone_out);
        repeat (80) @(posedge clk);
        #1 chk("term_high", 16'h0001, tone_out);
        strobe(8'h98, 12);
        strobe(8'h92, 48);
        strobe(8'h9A, 12);
        r = 8'h03 + 8'($random(seed) & 15);
        run(1'b0, 8'h34, 16'h0005);
        run(1'b0, 8'h35, 16'h0010);
        run(1'b0, 8'h14, {8'h00, r});
        run(1'b0, 8'h24, 16'h0100);
        run(1'b0, 8'h36, 16'h0006);
        run(1'b0, 8'h3C, 16'h0003);
        wr(ADDR_CTRL, 8'h32);
        wr(ADDR_CTRL, 8'h3A);
        meas(1'b0, per, lo); chk("refused", 16'd36, 16'(per));
        prog(ADDR_CNT_GEN, 8'h30, 16'h1000);
        repeat (50) @(posedge clk);
        wr(ADDR_CTRL, 8'h00); c1 = cyc;
        rd(ADDR_CNT_GEN, d); v1[7:0] = d; rd(ADDR_CNT_GEN, d); v1[15:8] = d;
        repeat (600) @(posedge clk);
        wr(ADDR_CTRL, 8'h00); lo = (cyc - c1) / 12;
        rd(ADDR_CNT_GEN, d); v2[7:0] = d; rd(ADDR_CNT_GEN, d); v2[15:8] = d;
        per = int'(v1) - int'(v2);
        chk("latch_step", 16'h0001, 16'(per >= lo - 1 && per <= lo + 1));
        end_sim();
    end

    // Watchdog against a hung handshake or silent output
    initial begin
        repeat (80000) @(posedge clk);
        err_count++;
        end_sim();
    end
endmodule : two_channel_interval_timer_bench
`default_nettype wire
